// [design/tmra_channel.sv]
// Functional notes
// [R1] Timer mode counts f1, f8, f32 or the subclock divided by 32.
// [R2] Timer mode counts down, reloads on underflow; ratio 1/(n+1).
// [R3] Writing the start flag to 1 starts counting.
// [R4] Clearing the start flag to 0 halts counting.
// [R5] Each timer-mode underflow raises the interrupt request.
// [R6] Count write while stopped loads both reload register and counter.
// [R7] Count write while running loads reload only; counter takes it at reload.
// [R8] Count read while running returns the live counter.
// [R9] Timer-mode read at the reload instant returns all ones.
// [R10] Read after a write while halted returns the written value.
// [R11] Gate option: input pin level enables or suspends counting.
// [R12] Pulse option: output pin toggles at every underflow.
// [R13] Event mode counts the input pin or another timer's overflow.
// [R14] Channels 0-1 single-phase only; channels 2-4 also two-phase.
// [R15] Event-mode reload-instant read: all ones on underflow, zeros on overflow.
// [R16] Software rewrites the count before restarting a stopped free-run channel.
// [R17] Event mode free-run wraps without reloading.
// [R18] Direction flag 0 counts down, 1 counts up in event mode.
// [R19] Counter and reload are 16 bits; underflow is a decrement at zero.
// [R20] Closed gate holds the counter; counting resumes from that value.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tmra_params.svh"

module tmra_channel #(
  parameter int unsigned CHAN_IDX = 0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_event_input_pin,
  input  wire logic        timer_phase_b_pin,
  input  wire logic        other_timer_overflow,
  input  wire logic        subclock_in,
  output logic             timer_pulse_output_pin,
  output logic             timer_pulse_output_oe,
  output logic             count_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0]        cnt_q;
  logic [15:0]        cnt_d;
  logic [15:0]        reload_q;
  logic               start_q;
  tmra_pkg::tmra_cfg_t cfg_q;
  logic [4:0]         div_q;
  logic [4:0]         sub_div_q;
  logic               sub_prev_q;
  logic               ev_prev_q;
  logic               out_q;
  logic               irq_q;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;

  // Two-phase input exists only on the upper channels
  localparam bit TWO_PH_OK = (CHAN_IDX >= 2);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One counter step; the 16-bit result wraps at both ends
  function automatic logic [15:0] step_cnt(input logic [15:0] v, input logic up);
    return up ? v + 16'h0001 : v - 16'h0001;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire setup_ph  = psel & ~penable;
  wire acc_ph    = psel & penable & pready_q;
  wire hit_cnt   = (paddr == `TMRA_OFF_COUNT);
  wire hit_start = (paddr == `TMRA_OFF_START);
  wire hit_mode  = (paddr == `TMRA_OFF_MODE);
  wire hit_stat  = (paddr == `TMRA_OFF_STATUS);
  wire addr_ok   = hit_cnt | hit_start | hit_mode | hit_stat;
  wire wr_ok     = acc_ph & pwrite & ~pslverr_q;
  wire wr_cnt    = wr_ok & hit_cnt;
  wire wr_start  = wr_ok & hit_start;
  wire wr_mode   = wr_ok & hit_mode;
  wire rd_setup  = setup_ph & ~pwrite;

  // ----------------------------------------------------------------
  // Count sources
  // ----------------------------------------------------------------
  wire is_timer  = (cfg_q.mode == tmra_pkg::TMRA_MODE_TIMER);
  wire is_event  = (cfg_q.mode == tmra_pkg::TMRA_MODE_EVENT);
  wire tick_f8   = ((div_q & `TMRA_DIV8_MASK) == `TMRA_DIV8_LAST);
  wire tick_f32  = (div_q == `TMRA_DIV32_LAST);
  wire sub_rise  = subclock_in & ~sub_prev_q;
  wire subclock_div32_source = sub_rise & (sub_div_q == `TMRA_DIV32_LAST);
  logic timer_tick;

  always_comb begin
    unique case (cfg_q.clk_sel) // [R1]
      tmra_pkg::TMRA_SRC_F1:   timer_tick = 1'b1;
      tmra_pkg::TMRA_SRC_F8:   timer_tick = tick_f8;
      tmra_pkg::TMRA_SRC_F32:  timer_tick = tick_f32;
      tmra_pkg::TMRA_SRC_SUB32: timer_tick = subclock_div32_source;
    endcase
  end

  // Gate is level sensitive; high lets the prescaled clock through
  wire gate_open  = ~cfg_q.gate_en | timer_event_input_pin; // [R11] [R20]
  wire ev_rise    = timer_event_input_pin & ~ev_prev_q;
  wire event_tick = cfg_q.ev_from_timer ? other_timer_overflow : ev_rise; // [R13]
  wire two_ph     = TWO_PH_OK & cfg_q.two_phase & ~cfg_q.ev_from_timer; // [R14]
  // Two-phase: phase B high at an A rising edge counts up, low counts down
  wire ev_up      = two_ph ? timer_phase_b_pin : cfg_q.channel_direction_flag; // [R18]
  wire count_up   = is_event & ev_up;
  wire timer_go   = is_timer & timer_tick & gate_open;
  wire event_go   = is_event & event_tick;
  wire count_en   = start_q & (timer_go | event_go); // [R3] [R4]

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  wire underflow  = count_en & ~count_up & (cnt_q == `TMRA_CNT_ZERO); // [R19]
  wire overflow   = count_en & count_up & (cnt_q == `TMRA_CNT_ONES);
  wire wrap       = underflow | overflow;
  wire reload_now = wrap & ~(is_event & cfg_q.free_run); // [R2] [R17]

  always_comb begin
    cnt_d = cnt_q;
    if (wr_cnt && !start_q) begin
      cnt_d = pwdata[15:0]; // [R6]
    end else if (reload_now) begin
      cnt_d = reload_q; // [R2] [R7]
    end else if (count_en) begin
      cnt_d = step_cnt(cnt_q, count_up); // [R17] [R18]
    end
  end

  // Reload-instant reads show the boundary, not the freshly loaded value
  wire [15:0] cnt_rd  = underflow ? `TMRA_CNT_ONES : overflow ? `TMRA_CNT_ZERO : cnt_q; // [R8] [R9] [R15]
  wire [31:0] stat_rd = {29'h0000000, cfg_q.gate_en & ~timer_event_input_pin, out_q, start_q};
  wire [31:0] rd_mux  = hit_cnt   ? {16'h0000, cnt_rd} :
                        hit_start ? {31'h00000000, start_q} :
                        hit_mode  ? {22'h000000, cfg_q} :
                        hit_stat  ? stat_rd : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= `TMRA_RST_COUNT;
      reload_q <= `TMRA_RST_RELOAD;
    end else begin
      cnt_q <= cnt_d;
      if (wr_cnt) begin
        reload_q <= pwdata[15:0]; // [R6] [R7]
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      cfg_q   <= tmra_pkg::tmra_cfg_t'(`TMRA_RST_MODE);
    end else begin
      if (wr_start) begin
        start_q <= pwdata[`TMRA_START_BIT]; // [R3] [R4]
      end
      if (wr_mode) begin
        cfg_q <= tmra_pkg::tmra_cfg_t'(pwdata[9:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and edge history
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q      <= 5'h00;
      sub_div_q  <= 5'h00;
      sub_prev_q <= 1'b0;
      ev_prev_q  <= 1'b0;
    end else begin
      div_q      <= div_q + 5'h01;
      sub_prev_q <= subclock_in;
      ev_prev_q  <= timer_event_input_pin;
      if (sub_rise) begin
        sub_div_q <= sub_div_q + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pulse output and interrupt request
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_q <= wrap; // [R5]
      if (wrap && cfg_q.pulse_en) begin
        out_q <= ~out_q; // [R12]
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait-free access phase after each setup
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & ~addr_ok;
      // Read data is captured at setup, so the access cycle never stalls
      if (rd_setup) begin
        prdata_q <= rd_mux; // [R8] [R10]
      end
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign count_irq              = irq_q;
  assign timer_pulse_output_pin = out_q;
  // Pin stays a general-purpose port unless pulse output is chosen
  assign timer_pulse_output_oe  = cfg_q.pulse_en; // [R12]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_underflow_reload: assert property ( // [R2]
    underflow && !is_event |=> cnt_q == $past(reload_q))
    else $error("counter did not reload after underflow");

  chk_down_step: assert property ( // [R2]
    count_en && !wrap && !count_up |=> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("counter did not step down by one");

  chk_irq_on_wrap: assert property ( // [R5]
    wrap |=> count_irq ##1 (!count_irq || $past(wrap)))
    else $error("interrupt request not a pulse on wrap");

  chk_pulse_toggle: assert property ( // [R12]
    wrap && cfg_q.pulse_en |=> timer_pulse_output_pin != $past(timer_pulse_output_pin))
    else $error("pulse output did not toggle");

  chk_stop_holds: assert property ( // [R4]
    !start_q && !wr_cnt |=> $stable(cnt_q))
    else $error("stopped counter moved");

  chk_write_stopped: assert property ( // [R6]
    wr_cnt && !start_q |=> cnt_q == $past(pwdata[15:0]) && reload_q == $past(pwdata[15:0]))
    else $error("stopped write did not reach both registers");

  chk_write_running: assert property ( // [R7]
    wr_cnt && start_q && !count_en |=> $stable(cnt_q) && reload_q == $past(pwdata[15:0]))
    else $error("running write disturbed counter");

  chk_reload_read: assert property ( // [R9]
    setup_ph && !pwrite && hit_cnt && underflow |=> prdata == 32'h0000FFFF)
    else $error("reload-instant read not all ones");

  chk_gate_hold: assert property ( // [R20]
    is_timer && cfg_q.gate_en && !timer_event_input_pin && !wr_cnt |=> $stable(cnt_q))
    else $error("closed gate did not hold counter");

  chk_free_run: assert property ( // [R17]
    overflow && is_event && cfg_q.free_run |=> cnt_q == 16'h0000)
    else $error("free-run overflow did not wrap");

  chk_up_step: assert property ( // [R18]
    count_en && !wrap && count_up |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not step up by one");

  // prdata holds the counter as it stood at the setup edge
  chk_live_read: assert property ( // [R8] [R10]
    rd_setup && hit_cnt && !wrap |=> prdata == {16'h0000, $past(cnt_q)})
    else $error("count read did not return the counter");

  chk_irq_quiet: assert property ( // [R5]
    !wrap |=> !count_irq)
    else $error("interrupt request without wrap");

  chk_pulse_hold: assert property ( // [R12]
    !(wrap && cfg_q.pulse_en) |=> $stable(timer_pulse_output_pin))
    else $error("pulse output moved without wrap");

  chk_single_phase: assert property ( // [R14]
    is_event && !TWO_PH_OK |-> count_up == cfg_q.channel_direction_flag)
    else $error("two-phase counting on a single-phase channel");

  chk_start_write: assert property ( // [R3] [R4]
    wr_start |=> start_q == $past(pwdata[`TMRA_START_BIT]))
    else $error("start flag write not applied");

  chk_event_hold: assert property ( // [R13]
    is_event && !event_tick && !wr_cnt |=> $stable(cnt_q))
    else $error("event counter moved without an event");

  chk_reload_idle: assert property ( // [R7]
    !wr_cnt |=> $stable(reload_q))
    else $error("reload register changed without a write");

  chk_ready_after_setup: assert property (
    psel && !penable |=> pready)
    else $error("no ready after setup");

  chk_ready_single: assert property (
    pready |=> !pready)
    else $error("ready longer than one cycle");

  chk_error_no_write: assert property (
    acc_ph && pslverr_q |=> $stable(reload_q) && $stable(start_q) && $stable(cfg_q))
    else $error("refused access changed a register");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  cov_timer_underflow: cover property (underflow && is_timer && cfg_q.pulse_en);
  cov_event_overflow:  cover property (overflow && is_event);
  cov_reload_read:     cover property (setup_ph && !pwrite && hit_cnt && wrap);
  cov_gate_closed:     cover property (is_timer && start_q && cfg_q.gate_en && !gate_open);
  cov_free_run_wrap:   cover property (overflow && is_event && cfg_q.free_run);

endmodule

`default_nettype wire

// [include/tmra_params.svh]
`ifndef TMRA_PARAMS_SVH
`define TMRA_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define TMRA_OFF_COUNT   12'h000
`define TMRA_OFF_START   12'h004
`define TMRA_OFF_MODE    12'h008
`define TMRA_OFF_STATUS  12'h00C

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define TMRA_CNT_W       16
`define TMRA_MODE_W      10
`define TMRA_START_BIT   0
`define TMRA_STAT_RUN    0
`define TMRA_STAT_OUT    1
`define TMRA_STAT_GATE   2

// ----------------------------------------------------------------
// Reset values and special read values
// ----------------------------------------------------------------
`define TMRA_RST_COUNT   16'h0000
`define TMRA_RST_RELOAD  16'h0000
`define TMRA_RST_MODE    10'h000
`define TMRA_CNT_ONES    16'hFFFF
`define TMRA_CNT_ZERO    16'h0000

// ----------------------------------------------------------------
// Prescaler terminal counts
// ----------------------------------------------------------------
`define TMRA_DIV8_LAST   5'h07
`define TMRA_DIV32_LAST  5'h1F
`define TMRA_DIV8_MASK   5'h07

`endif

// [include/tmra_pkg.sv]
package tmra_pkg;

  typedef enum logic [1:0] {
    TMRA_MODE_TIMER = 2'b00,
    TMRA_MODE_EVENT = 2'b01,
    TMRA_MODE_RSV2  = 2'b10,
    TMRA_MODE_RSV3  = 2'b11
  } tmra_mode_t;

  typedef enum logic [1:0] {
    TMRA_SRC_F1   = 2'b00,
    TMRA_SRC_F8   = 2'b01,
    TMRA_SRC_F32  = 2'b10,
    TMRA_SRC_SUB32 = 2'b11
  } tmra_clksel_t;

  // Mode register layout, bit 9 down to bit 0
  typedef struct packed {
    logic         channel_direction_flag;
    logic         two_phase;
    logic         ev_from_timer;
    logic         free_run;
    logic         pulse_en;
    logic         gate_en;
    tmra_clksel_t clk_sel;
    tmra_mode_t   mode;
  } tmra_cfg_t;

endpackage

// [tb/tmra_channel_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tmra_channel_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic        pready;
  logic        pslverr;
  logic        slv;
  logic        ev_pin;
  logic        ph_b;
  logic        oth_ovf;
  logic        sub_clk = 1'b0;
  logic        pout;
  logic        pout_oe;
  logic        irq;
  logic        p0;
  logic [15:0] seed;
  logic [15:0] n;
  int          error_cnt;
  int          checked;
  int          irq_cnt;
  int          t;

  tmra_channel dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_event_input_pin(ev_pin), .timer_phase_b_pin(ph_b), .other_timer_overflow(oth_ovf),
    .subclock_in(sub_clk), .timer_pulse_output_pin(pout), .timer_pulse_output_oe(pout_oe),
    .count_irq(irq));

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  // Subclock rises every second cycle, so its divided source ticks once per 64 cycles
  always @(posedge pclk) sub_clk <= ~sub_clk;
  always @(posedge pclk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

  // ----------------------------------------------------------------
  // Reference model and helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int period(input int cnt, input int s);
    int div[4] = '{1, 8, 32, 64};
    return (cnt + 1) * div[s];
  endfunction

  task automatic close_out();
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One idle edge first, so a release is never overwritten in its own step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 8) begin
      error_cnt++;
      close_out();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_irq();
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (irq !== 1'b1 && t < 9000);
    if (t >= 9000) begin
      error_cnt++;
      close_out();
    end
  endtask

  task automatic pulse(input int k, input logic oth);
    repeat (k) begin
      @(posedge pclk);
      ev_pin <= !oth;
      oth_ovf <= oth;
      @(posedge pclk);
      ev_pin <= 1'b0;
      oth_ovf <= 1'b0;
    end
    repeat (4) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ev_pin, ph_b, oth_ovf} = '0;
    error_cnt = 0;
    checked = 0;
    seed = 16'h0029;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    cmp({31'h0, slv}, 32'h1);
    for (int s = 0; s < 4; s++) begin
      seed = lfsr(seed);
      n = (s == 0) ? {8'h00, seed[7:0]} : 16'h0001;
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h000, {16'h0, n});
      apb(1'b0, 12'h000, 32'h0);
      cmp(rd, {16'h0, n});
      apb(1'b1, 12'h008, 32'h20 | (s << 2));
      apb(1'b1, 12'h004, 32'h1);
      cmp({31'h0, pout_oe}, 32'h1);
      wait_irq();
      p0 = pout;
      wait_irq();
      cmp(t, period(n, s));
      cmp({31'h0, pout}, {31'h0, !p0});
    end
    // Live reads, then a reload-only write while running
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h000, 32'h0400);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    rd2 = rd;
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd2 - rd, 32'h3);
    rd2 = rd;
    apb(1'b1, 12'h000, 32'h5);
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd2 - rd, 32'h6);
    wait_irq();
    wait_irq();
    cmp(t, period(5, 0));
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    rd2 = rd;
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, rd2);
    // Zero reload wraps every tick, so every read meets the reload instant
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'h0000FFFF);
    wait_irq();
    wait_irq();
    cmp(t, 32'h1);
    // Gate held closed, written while closed, then opened
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h008, 32'h10);
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b1, 12'h004, 32'h1);
    repeat (20) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h7);
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'h3);
    apb(1'b0, 12'h00C, 32'h0);
    cmp(rd & 32'h5, 32'h5);
    ev_pin <= 1'b1;
    wait_irq();
    wait_irq();
    cmp(t, period(7, 0));
    ev_pin <= 1'b0;
    // Event counting from the pin (two-phase asked, single-phase channel) and from another timer
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h2);
    ph_b <= 1'b1;
    apb(1'b1, 12'h008, 32'h101);
    apb(1'b1, 12'h004, 32'h1);
    t = irq_cnt;
    pulse(3, 1'b0);
    cmp(irq_cnt - t, 32'h1);
    ph_b <= 1'b0;
    apb(1'b1, 12'h008, 32'h81);
    t = irq_cnt;
    pulse(3, 1'b1);
    cmp(irq_cnt - t, 32'h1);
    // Up count in free run passes the top without reloading
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'hFFFE);
    apb(1'b1, 12'h008, 32'h241);
    apb(1'b1, 12'h004, 32'h1);
    pulse(3, 1'b0);
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'h1);
    // A stopped free-run channel is rewritten before it restarts
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'hFFFE);
    apb(1'b1, 12'h004, 32'h1);
    pulse(2, 1'b0);
    apb(1'b0, 12'h000, 32'h0);
    cmp(rd, 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
